// ### t16wm_pkg.sv
/*
 Package for the 16-bit timer waveform mode control: register map, field
 positions, mode codes, top values and the state carriers.
 Assumes a plain register port with 8-bit data and one-cycle read latency.
*/
package t16wm_pkg;
  localparam int unsigned T16WM_CLK_HZ = 25_000_000;

  // Register indices on the plain port
  localparam logic [3:0] T16WM_ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] T16WM_ADDR_CTRL_B = 4'h1;
  localparam logic [3:0] T16WM_ADDR_CMP_A_LO = 4'h2;
  localparam logic [3:0] T16WM_ADDR_CMP_A_HI = 4'h3;
  localparam logic [3:0] T16WM_ADDR_CMP_B_LO = 4'h4;
  localparam logic [3:0] T16WM_ADDR_CMP_B_HI = 4'h5;
  localparam logic [3:0] T16WM_ADDR_CAP_LO = 4'h6;
  localparam logic [3:0] T16WM_ADDR_CAP_HI = 4'h7;
  localparam logic [3:0] T16WM_ADDR_CNT_LO = 4'h8;
  localparam logic [3:0] T16WM_ADDR_CNT_HI = 4'h9;
  localparam logic [3:0] T16WM_ADDR_STATUS = 4'hA;
  localparam logic [3:0] T16WM_ADDR_DIR = 4'hB;

  // Control A fields
  localparam int T16WM_CA_ACT_A_HI = 7;
  localparam int T16WM_CA_ACT_A_LO = 6;
  localparam int T16WM_CA_ACT_B_HI = 5;
  localparam int T16WM_CA_ACT_B_LO = 4;
  localparam int T16WM_CA_FORCE_A = 3;
  localparam int T16WM_CA_FORCE_B = 2;
  localparam int T16WM_CA_MODE_HI = 1;
  localparam int T16WM_CA_MODE_LO = 0;
  // Control B fields
  localparam int T16WM_CB_MODE_HI = 4;
  localparam int T16WM_CB_MODE_LO = 3;
  localparam int T16WM_CB_RUN = 0;
  localparam logic [7:0] T16WM_CA_RD_MASK = 8'hF3;
  localparam logic [7:0] T16WM_CB_RD_MASK = 8'h19;
  localparam logic [7:0] T16WM_RESET_8 = 8'h00;
  localparam logic [15:0] T16WM_RESET_16 = 16'h0000;

  // Output action codes
  localparam logic [1:0] T16WM_ACT_OFF = 2'h0;
  localparam logic [1:0] T16WM_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] T16WM_ACT_CLEAR = 2'h2;
  localparam logic [1:0] T16WM_ACT_SET = 2'h3;

  // Mode selector codes
  localparam logic [3:0] T16WM_MODE_NORMAL = 4'h0;
  localparam logic [3:0] T16WM_MODE_PC8 = 4'h1;
  localparam logic [3:0] T16WM_MODE_PC9 = 4'h2;
  localparam logic [3:0] T16WM_MODE_PC10 = 4'h3;
  localparam logic [3:0] T16WM_MODE_CTC_CMP = 4'h4;
  localparam logic [3:0] T16WM_MODE_FAST8 = 4'h5;
  localparam logic [3:0] T16WM_MODE_FAST9 = 4'h6;
  localparam logic [3:0] T16WM_MODE_FAST10 = 4'h7;
  localparam logic [3:0] T16WM_MODE_PFC_CAP = 4'h8;
  localparam logic [3:0] T16WM_MODE_PFC_CMP = 4'h9;
  localparam logic [3:0] T16WM_MODE_PC_CAP = 4'hA;
  localparam logic [3:0] T16WM_MODE_PC_CMP = 4'hB;
  localparam logic [3:0] T16WM_MODE_CTC_CAP = 4'hC;
  localparam logic [3:0] T16WM_MODE_RSVD = 4'hD;
  localparam logic [3:0] T16WM_MODE_FAST_CAP = 4'hE;
  localparam logic [3:0] T16WM_MODE_FAST_CMP = 4'hF;

  localparam logic [15:0] T16WM_TOP_MAX = 16'hFFFF;
  localparam logic [15:0] T16WM_TOP_8 = 16'h00FF;
  localparam logic [15:0] T16WM_TOP_9 = 16'h01FF;
  localparam logic [15:0] T16WM_TOP_10 = 16'h03FF;
  localparam logic [15:0] T16WM_BOTTOM = 16'h0000;
  localparam logic [15:0] T16WM_ONE = 16'h0001;

  typedef enum logic [1:0] {
    T16WM_WF_SINGLE,
    T16WM_WF_FAST,
    T16WM_WF_DUAL
  } t16wm_wave_t;

  typedef enum logic [1:0] {
    T16WM_UPD_NOW,
    T16WM_UPD_TOP,
    T16WM_UPD_BOTTOM
  } t16wm_upd_t;

  // Decoded mode
  typedef struct packed {
    t16wm_wave_t wave;
    t16wm_upd_t reload;
    t16wm_upd_t ovf_at;
    logic [15:0] top;
    logic clear_on_top;
  } t16wm_mode_t;

  // Per-channel event carrier
  typedef struct packed {
    logic match;
    logic at_top;
    logic counting_up;
    logic forced;
  } t16wm_chan_ev_t;
endpackage

// ### t16wm_mode_decode.sv
/*
 Mode selector decoder: turns the four-bit wave mode into waveform type,
 top value, reload point and overflow point.
 Assumes capture and channel A compare values are stable for the cycle.
*/
`timescale 1ns/100ps
module t16wm_mode_decode
  import t16wm_pkg::*;
(
  input wire logic [3:0] wave_mode_select_in,
  input wire logic [15:0] chan_a_compare_in,
  input wire logic [15:0] capture_value_in,
  output t16wm_mode_t mode_out
);
  always_comb begin
    mode_out = '{T16WM_WF_SINGLE, T16WM_UPD_NOW, T16WM_UPD_NOW, T16WM_TOP_MAX, 1'b0};
    unique case (wave_mode_select_in)
      T16WM_MODE_NORMAL: begin
        mode_out.top = T16WM_TOP_MAX;
      end
      T16WM_MODE_CTC_CMP: begin
        mode_out.top = chan_a_compare_in;
        mode_out.clear_on_top = 1'b1;
      end
      T16WM_MODE_CTC_CAP: begin
        mode_out.top = capture_value_in;
        mode_out.clear_on_top = 1'b1;
      end
      T16WM_MODE_PC8, T16WM_MODE_PC9, T16WM_MODE_PC10,
      T16WM_MODE_PC_CAP, T16WM_MODE_PC_CMP: begin
        mode_out.wave = T16WM_WF_DUAL;
        mode_out.reload = T16WM_UPD_TOP;
        mode_out.ovf_at = T16WM_UPD_BOTTOM;
        if (wave_mode_select_in == T16WM_MODE_PC8) begin
          mode_out.top = T16WM_TOP_8;
        end else if (wave_mode_select_in == T16WM_MODE_PC9) begin
          mode_out.top = T16WM_TOP_9;
        end else if (wave_mode_select_in == T16WM_MODE_PC10) begin
          mode_out.top = T16WM_TOP_10;
        end else if (wave_mode_select_in == T16WM_MODE_PC_CAP) begin
          mode_out.top = capture_value_in;
        end else begin
          mode_out.top = chan_a_compare_in;
        end
      end
      T16WM_MODE_FAST8, T16WM_MODE_FAST9, T16WM_MODE_FAST10,
      T16WM_MODE_FAST_CAP, T16WM_MODE_FAST_CMP: begin
        mode_out.wave = T16WM_WF_FAST;
        mode_out.reload = T16WM_UPD_TOP;
        mode_out.ovf_at = T16WM_UPD_TOP;
        mode_out.clear_on_top = 1'b1;
        if (wave_mode_select_in == T16WM_MODE_FAST8) begin
          mode_out.top = T16WM_TOP_8;
        end else if (wave_mode_select_in == T16WM_MODE_FAST9) begin
          mode_out.top = T16WM_TOP_9;
        end else if (wave_mode_select_in == T16WM_MODE_FAST10) begin
          mode_out.top = T16WM_TOP_10;
        end else if (wave_mode_select_in == T16WM_MODE_FAST_CAP) begin
          mode_out.top = capture_value_in;
        end else begin
          mode_out.top = chan_a_compare_in;
        end
      end
      T16WM_MODE_PFC_CAP, T16WM_MODE_PFC_CMP: begin
        mode_out.wave = T16WM_WF_DUAL;
        mode_out.reload = T16WM_UPD_BOTTOM;
        mode_out.ovf_at = T16WM_UPD_BOTTOM;
        mode_out.top = (wave_mode_select_in == T16WM_MODE_PFC_CAP) ?
                       capture_value_in : chan_a_compare_in;
      end
      T16WM_MODE_RSVD: begin
        // Undefined selector: behaves as normal mode, nothing promised
        mode_out.top = T16WM_TOP_MAX;
      end
    endcase
  end
endmodule

// ### t16wm_top.sv
/*
 16-bit timer waveform mode control: counter, two compare channels with
 output actions, force strobes, buffered compare reloads and overflow flag.
 Assumes a plain synchronous register port and a one-cycle timer enable
 from an outside prescaler.
*/
// The address-and-strobe port and the register offsets were decided locally.
// How it works
// - nonzero action field gives pin to compare, except PWM 01 when A does not toggle
// - driver enabled only if direction bit outputs
// - non-PWM: off, toggle, clear, set on match
// - PWM action 01: off, or A toggles
// - fast PWM: 10 clear-match set-top, 11 inverse
// - fast PWM compare equal top: top action only
// - dual slope: 10 clear up, set down
// - force strobes act only in non-PWM modes
// - strobe forces match now, no storage
// - forced match sets no flag, no clear
// - strobe bit positions always read zero
// - four mode bits from two control registers
// - normal and CLEAR_ON_MATCH_MODE tops, immediate, max flag
// - phase correct tops, reload top, flag bottom
// - fast PWM tops, reload and flag top
// - phase-frequency correct tops, bottom reload and flag
// - dual slope extremes hold steady levels
// - high mode bits at control B 4:3
`timescale 1ns/100ps
module t16wm_top
  import t16wm_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic timer_tick_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] port_a_gpio_in,
  input wire logic [7:0] port_b_gpio_in,
  output logic [7:0] reg_rdata_out,
  output logic chan_a_wave_out,
  output logic chan_b_wave_out,
  output logic chan_a_pin_out,
  output logic chan_a_pin_oe_out,
  output logic chan_b_pin_out,
  output logic chan_b_pin_oe_out,
  output logic overflow_flag_out
);
  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [15:0] cmp_a_buf;
    logic [15:0] cmp_b_buf;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] capture;
    logic [15:0] count;
    logic count_up;
    logic [7:0] wr_hold;
    logic [1:0] dir;
    logic [1:0] wave;
    logic [1:0] pin;
    logic [1:0] pin_oe;
    logic ovf;
    logic [7:0] rdata;
  } t16wm_state_t;

  t16wm_state_t st;
  t16wm_state_t next_st;
  t16wm_mode_t mode;
  logic [3:0] wave_mode_select;
  logic [1:0] chan_output_action [2];
  logic [15:0] chan_cmp [2];
  logic [1:0] force_strobe;
  logic wr_ctrl_a;
  logic at_top;
  logic at_bottom;

  // Only bits 1:0 of ctrl_a and 4:3 of ctrl_b form the selector
  assign wave_mode_select = {st.ctrl_b[T16WM_CB_MODE_HI:T16WM_CB_MODE_LO],
                             st.ctrl_a[T16WM_CA_MODE_HI:T16WM_CA_MODE_LO]};
  assign chan_output_action[0] = st.ctrl_a[T16WM_CA_ACT_A_HI:T16WM_CA_ACT_A_LO];
  assign chan_output_action[1] = st.ctrl_a[T16WM_CA_ACT_B_HI:T16WM_CA_ACT_B_LO];
  assign chan_cmp[0] = st.cmp_a;
  assign chan_cmp[1] = st.cmp_b;
  assign wr_ctrl_a = reg_wr_in && (reg_addr_in == T16WM_ADDR_CTRL_A);
  // Strobes come straight from the write data, never stored
  assign force_strobe = wr_ctrl_a ?
                        {reg_wdata_in[T16WM_CA_FORCE_B], reg_wdata_in[T16WM_CA_FORCE_A]} :
                        2'h0;
  assign at_top = (st.count == mode.top);
  assign at_bottom = (st.count == T16WM_BOTTOM);

  t16wm_mode_decode u_decode (
    .wave_mode_select_in(wave_mode_select),
    .chan_a_compare_in(st.cmp_a),
    .capture_value_in(st.capture),
    .mode_out(mode)
  );

  always_comb begin
    logic running;
    logic [1:0] act;
    logic lvl;
    t16wm_chan_ev_t ev;
    running = 1'b0;
    act = T16WM_ACT_OFF;
    lvl = 1'b0;
    ev = '0;
    next_st = st;
    running = timer_tick_in && st.ctrl_b[T16WM_CB_RUN];

    // Counter sequencing
    if (running) begin
      if (mode.wave == T16WM_WF_DUAL) begin
        if (st.count_up && at_top) begin
          next_st.count_up = 1'b0;
          next_st.count = st.count - T16WM_ONE;
        end else if (!st.count_up && at_bottom) begin
          next_st.count_up = 1'b1;
          next_st.count = st.count + T16WM_ONE;
        end else if (st.count_up) begin
          next_st.count = st.count + T16WM_ONE;
        end else begin
          next_st.count = st.count - T16WM_ONE;
        end
      end else begin
        next_st.count_up = 1'b1;
        next_st.count = (mode.clear_on_top && at_top) ? T16WM_BOTTOM : st.count + T16WM_ONE;
      end
      // Overflow point per mode
      if ((mode.ovf_at == T16WM_UPD_NOW && st.count == T16WM_TOP_MAX) ||
          (mode.ovf_at == T16WM_UPD_TOP && at_top) ||
          (mode.ovf_at == T16WM_UPD_BOTTOM && at_bottom && !st.count_up)) begin
        next_st.ovf = 1'b1;
      end
      // Double-buffered compare reload
      if ((mode.reload == T16WM_UPD_TOP && at_top) ||
          (mode.reload == T16WM_UPD_BOTTOM && at_bottom)) begin
        next_st.cmp_a = st.cmp_a_buf;
        next_st.cmp_b = st.cmp_b_buf;
      end
    end
    if (mode.reload == T16WM_UPD_NOW) begin
      next_st.cmp_a = st.cmp_a_buf;
      next_st.cmp_b = st.cmp_b_buf;
    end

    // Waveform per channel
    for (int ch = 0; ch < 2; ch++) begin
      act = chan_output_action[ch];
      lvl = st.wave[ch];
      ev.match = running && (st.count == chan_cmp[ch]);
      ev.at_top = running && at_top;
      ev.counting_up = st.count_up;
      // Forced compare touches only the output, not flags or count
      ev.forced = force_strobe[ch] && (mode.wave == T16WM_WF_SINGLE);
      if (mode.wave == T16WM_WF_SINGLE) begin
        if (ev.match || ev.forced) begin
          unique case (act)
            T16WM_ACT_OFF: lvl = st.wave[ch];
            T16WM_ACT_TOGGLE: lvl = ~st.wave[ch];
            T16WM_ACT_CLEAR: lvl = 1'b0;
            T16WM_ACT_SET: lvl = 1'b1;
          endcase
        end
      end else if (act == T16WM_ACT_TOGGLE) begin
        if (ch == 0 && wave_mode_select[3] && ev.match) begin
          lvl = ~st.wave[ch];
        end
      end else if (act[1] && mode.wave == T16WM_WF_FAST) begin
        // Top action wins, so a match at top is ignored
        if (ev.at_top) begin
          lvl = ~act[0];
        end else if (ev.match) begin
          lvl = act[0];
        end
      end else if (act[1]) begin
        // Compare at bottom or top gives a constant level
        if (chan_cmp[ch] == T16WM_BOTTOM) begin
          lvl = act[0];
        end else if (chan_cmp[ch] == mode.top) begin
          lvl = ~act[0];
        end else if (ev.match) begin
          lvl = ev.counting_up ? act[0] : ~act[0];
        end
      end
      next_st.wave[ch] = lvl;
      // Pin ownership and driver enable
      if (act != T16WM_ACT_OFF &&
          !(mode.wave != T16WM_WF_SINGLE && act == T16WM_ACT_TOGGLE &&
            !(ch == 0 && wave_mode_select[3]))) begin
        next_st.pin[ch] = lvl;
      end else begin
        next_st.pin[ch] = (ch == 0) ? port_a_gpio_in[0] : port_b_gpio_in[0];
      end
      next_st.pin_oe[ch] = st.dir[ch];
    end

    // Register writes
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        T16WM_ADDR_CTRL_A: next_st.ctrl_a = reg_wdata_in & T16WM_CA_RD_MASK;
        T16WM_ADDR_CTRL_B: next_st.ctrl_b = reg_wdata_in & T16WM_CB_RD_MASK;
        T16WM_ADDR_CMP_A_LO: next_st.cmp_a_buf = {st.wr_hold, reg_wdata_in};
        T16WM_ADDR_CMP_B_LO: next_st.cmp_b_buf = {st.wr_hold, reg_wdata_in};
        T16WM_ADDR_CAP_LO: next_st.capture = {st.wr_hold, reg_wdata_in};
        T16WM_ADDR_CNT_LO: next_st.count = {st.wr_hold, reg_wdata_in};
        T16WM_ADDR_CMP_A_HI, T16WM_ADDR_CMP_B_HI,
        T16WM_ADDR_CAP_HI, T16WM_ADDR_CNT_HI: next_st.wr_hold = reg_wdata_in;
        T16WM_ADDR_STATUS: begin
          // Write one clears, unless a same-cycle overflow sets the flag from clear
          if (reg_wdata_in[0] && !(next_st.ovf && !st.ovf)) begin
            next_st.ovf = 1'b0;
          end
        end
        T16WM_ADDR_DIR: next_st.dir = reg_wdata_in[1:0];
        default: next_st.ovf = next_st.ovf;
      endcase
    end

    // Register reads, data in the next cycle
    next_st.rdata = T16WM_RESET_8;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        T16WM_ADDR_CTRL_A: next_st.rdata = st.ctrl_a & T16WM_CA_RD_MASK;
        T16WM_ADDR_CTRL_B: next_st.rdata = st.ctrl_b;
        T16WM_ADDR_CMP_A_LO: next_st.rdata = st.cmp_a_buf[7:0];
        T16WM_ADDR_CMP_A_HI: next_st.rdata = st.cmp_a_buf[15:8];
        T16WM_ADDR_CMP_B_LO: next_st.rdata = st.cmp_b_buf[7:0];
        T16WM_ADDR_CMP_B_HI: next_st.rdata = st.cmp_b_buf[15:8];
        T16WM_ADDR_CAP_LO: next_st.rdata = st.capture[7:0];
        T16WM_ADDR_CAP_HI: next_st.rdata = st.capture[15:8];
        T16WM_ADDR_CNT_LO: next_st.rdata = st.count[7:0];
        T16WM_ADDR_CNT_HI: next_st.rdata = st.count[15:8];
        T16WM_ADDR_STATUS: next_st.rdata = {7'h00, st.ovf};
        T16WM_ADDR_DIR: next_st.rdata = {6'h00, st.dir};
        default: next_st.rdata = T16WM_RESET_8;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_out = st.rdata;
  assign chan_a_wave_out = st.wave[0];
  assign chan_b_wave_out = st.wave[1];
  assign chan_a_pin_out = st.pin[0];
  assign chan_a_pin_oe_out = st.pin_oe[0];
  assign chan_b_pin_out = st.pin[1];
  assign chan_b_pin_oe_out = st.pin_oe[1];
  assign overflow_flag_out = st.ovf;
endmodule

// ### t16wm_asserts.sv
/*
 Checker for t16wm_top: control register readback, driver enables and the
 causes of waveform and flag changes.
 Assumes it is bound to t16wm_top and sees only its ports.
*/
`timescale 1ns/100ps
module t16wm_asserts
  import t16wm_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic timer_tick_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic chan_a_wave_out,
  input wire logic chan_b_wave_out,
  input wire logic chan_a_pin_oe_out,
  input wire logic chan_b_pin_oe_out,
  input wire logic overflow_flag_out
);
  logic [7:0] shadow_a;
  logic [7:0] shadow_b;
  logic dir_wr;
  logic cause;

  assign dir_wr = reg_wr_in && (reg_addr_in == T16WM_ADDR_DIR);
  // Writes change modes or force, ticks move the counter
  assign cause = timer_tick_in || reg_wr_in;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      shadow_a <= 8'h00;
      shadow_b <= 8'h00;
    end else if (reg_wr_in && reg_addr_in == T16WM_ADDR_CTRL_A) begin
      shadow_a <= reg_wdata_in;
    end else if (reg_wr_in && reg_addr_in == T16WM_ADDR_CTRL_B) begin
      shadow_b <= reg_wdata_in;
    end
  end

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_ctrl_a_readback: assert property (
    $past(reg_rd_in) && $past(reg_addr_in) == T16WM_ADDR_CTRL_A
    |-> reg_rdata_out == ($past(shadow_a) & T16WM_CA_RD_MASK))
    else $error("control A readback wrong");
  a_ctrl_b_readback: assert property (
    $past(reg_rd_in) && $past(reg_addr_in) == T16WM_ADDR_CTRL_B
    |-> reg_rdata_out == ($past(shadow_b) & T16WM_CB_RD_MASK))
    else $error("control B readback wrong");
  a_oe_drive_on: assert property (
    dir_wr && reg_wdata_in[1:0] == 2'h3 |-> ##[1:2] chan_a_pin_oe_out && chan_b_pin_oe_out)
    else $error("driver enables not raised");
  a_oe_drive_off: assert property (
    dir_wr && reg_wdata_in[1:0] == 2'h0 |-> ##[1:2] !chan_a_pin_oe_out && !chan_b_pin_oe_out)
    else $error("driver enables not lowered");
  a_oe_hold_still: assert property (
    $changed(chan_a_pin_oe_out) |-> $past(dir_wr) || $past(dir_wr, 2))
    else $error("driver enable moved without write");
  a_wave_a_cause: assert property (
    $changed(chan_a_wave_out) |-> $past(cause) || $past(cause, 2) || $past(cause, 3))
    else $error("wave A moved without tick or write");
  a_wave_b_cause: assert property (
    $changed(chan_b_wave_out) |-> $past(cause) || $past(cause, 2) || $past(cause, 3))
    else $error("wave B moved without tick or write");
  a_ovf_tick_only: assert property (
    $rose(overflow_flag_out)
    |-> $past(timer_tick_in) || $past(timer_tick_in, 2) || $past(timer_tick_in, 3))
    else $error("overflow set without a tick");
endmodule

bind t16wm_top t16wm_asserts t16wm_asserts_inst (
  .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .timer_tick_in(timer_tick_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .chan_a_wave_out(chan_a_wave_out), .chan_b_wave_out(chan_b_wave_out),
  .chan_a_pin_oe_out(chan_a_pin_oe_out), .chan_b_pin_oe_out(chan_b_pin_oe_out),
  .overflow_flag_out(overflow_flag_out)
);

// ### tb.sv
/*
 Self-checking bench for t16wm_top: registers, force strobes, pin
 muxing, overflow and waveform duty in several modes.
 Assumes the plain register port; the timer tick is driven from here.
*/
`timescale 1ns/100ps
module tb;
  import t16wm_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic tick = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] gpio_a = 8'h00;
  logic [7:0] gpio_b = 8'h00;
  logic [7:0] rdata;
  logic wave_a, wave_b, pin_a, pin_b, oe_a, oe_b, ovf;
  int miscompares = 0;
  int samples_checked = 0;
  int high_a, high_b, toggles;

  t16wm_top t16wm_top_inst (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .timer_tick_in(tick),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .port_a_gpio_in(gpio_a), .port_b_gpio_in(gpio_b), .reg_rdata_out(rdata),
    .chan_a_wave_out(wave_a), .chan_b_wave_out(wave_b), .chan_a_pin_out(pin_a),
    .chan_a_pin_oe_out(oe_a), .chan_b_pin_out(pin_b), .chan_b_pin_oe_out(oe_b),
    .overflow_flag_out(ovf)
  );

  always #20 core_clk_in = ~core_clk_in;

  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task cycles(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_in);
    wr <= 1'b0;
  endtask

  task rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_in);
    rd <= 1'b0;
    #1;
    chk(16'(rdata), 16'(exp));
  endtask

  task w16(input logic [3:0] lo, input logic [15:0] v);
    wr_reg(lo + 4'h1, v[15:8]);
    wr_reg(lo, v[7:0]);
  endtask

  // Stop and zero the counter so a lower top never strands it
  task setup(input logic [7:0] ca, input logic [7:0] cb);
    wr_reg(T16WM_ADDR_CTRL_B, 8'h00);
    w16(T16WM_ADDR_CNT_LO, 16'h0000);
    wr_reg(T16WM_ADDR_CTRL_A, ca);
    wr_reg(T16WM_ADDR_CTRL_B, cb);
    wr_reg(T16WM_ADDR_STATUS, 8'h01);
  endtask

  task wait_ovf(input int n);
    int i;
    // Step off the edge so a flag cleared on it is not seen as still set
    #1;
    for (i = 0; i < n && ovf !== 1'b1; i++) begin
      cycles(1);
    end
    chk(16'(ovf), 16'h0001);
    if (ovf !== 1'b1) begin
      give_verdict;
    end
  endtask

  // Window of n cycles; callers pass whole periods except the 520-cycle steady-level checks
  task measure(input int n);
    logic last;
    high_a = 0;
    high_b = 0;
    toggles = 0;
    last = wave_a;
    repeat (n) begin
      cycles(1);
      high_a += int'(wave_a === 1'b1);
      high_b += int'(wave_b === 1'b1);
      toggles += int'(wave_a !== last);
      last = wave_a;
    end
  endtask

  task t_regs;
    rd_chk(T16WM_ADDR_CTRL_A, 8'h00);
    rd_chk(T16WM_ADDR_CTRL_B, 8'h00);
    rd_chk(4'hF, 8'h00);
    wr_reg(T16WM_ADDR_CTRL_A, 8'hFC);
    rd_chk(T16WM_ADDR_CTRL_A, 8'hF0);
    chk(16'({wave_a, wave_b}), 16'h0000);
    wr_reg(T16WM_ADDR_CTRL_B, 8'hFE);
    rd_chk(T16WM_ADDR_CTRL_B, 8'h18);
    wr_reg(T16WM_ADDR_CTRL_A, 8'h03);
    rd_chk(T16WM_ADDR_CTRL_A, 8'h03);
  endtask

  task t_force;
    logic [1:0] act [4];
    logic exp_w [4];
    act = '{2'h3, 2'h1, 2'h1, 2'h2};
    exp_w = '{1'b1, 1'b0, 1'b1, 1'b0};
    setup(8'h00, 8'h08);
    w16(T16WM_ADDR_CNT_LO, 16'h0005);
    for (int i = 0; i < 4; i++) begin
      wr_reg(T16WM_ADDR_CTRL_A, {act[i], act[i], 4'h0});
      wr_reg(T16WM_ADDR_CTRL_A, {act[i], act[i], 4'hC});
      cycles(2);
      chk(16'({wave_a, wave_b}), 16'({exp_w[i], exp_w[i]}));
    end
    rd_chk(T16WM_ADDR_CNT_LO, 8'h05);
    chk(16'(ovf), 16'h0000);
    wr_reg(T16WM_ADDR_CTRL_A, 8'hF1);
    wr_reg(T16WM_ADDR_CTRL_A, 8'hFD);
    cycles(2);
    chk(16'({wave_a, wave_b}), 16'h0000);
  endtask

  task t_pin;
    setup(8'h00, 8'h00);
    wr_reg(T16WM_ADDR_DIR, 8'h03);
    gpio_b <= 8'h01;
    cycles(3);
    chk(16'({oe_a, oe_b, pin_a, pin_b}), 16'h000D);
    wr_reg(T16WM_ADDR_CTRL_A, 8'hE0);
    wr_reg(T16WM_ADDR_CTRL_A, 8'hEC);
    cycles(3);
    chk(16'({oe_a, oe_b, pin_a, pin_b}), 16'h000E);
    wr_reg(T16WM_ADDR_DIR, 8'h00);
    cycles(3);
    chk(16'({oe_a, oe_b, pin_a, pin_b}), 16'h0002);
  endtask

  task t_ovf;
    setup(8'h00, 8'h00);
    w16(T16WM_ADDR_CNT_LO, 16'hFFFD);
    tick <= 1'b1;
    wr_reg(T16WM_ADDR_CTRL_B, 8'h01);
    wait_ovf(10);
    wr_reg(T16WM_ADDR_CTRL_B, 8'h00);
    wr_reg(T16WM_ADDR_STATUS, 8'h01);
    cycles(2);
    chk(16'(ovf), 16'h0000);
  endtask

  task t_fast;
    w16(T16WM_ADDR_CMP_A_LO, 16'h0010);
    w16(T16WM_ADDR_CMP_B_LO, 16'h00FF);
    setup(8'hA1, 8'h09);
    wait_ovf(300);
    cycles(600);
    measure(256);
    chk(16'(high_a), 16'h0011);
    chk(16'(high_b), 16'h0100);
    wr_reg(T16WM_ADDR_CTRL_A, 8'hE1);
    cycles(300);
    measure(256);
    chk(16'(high_a), 16'h00EF);
  endtask

  task t_dual;
    w16(T16WM_ADDR_CMP_A_LO, 16'h0000);
    w16(T16WM_ADDR_CMP_B_LO, 16'h0000);
    setup(8'hB1, 8'h01);
    wait_ovf(600);
    cycles(1100);
    measure(520);
    chk(16'(high_a), 16'h0000);
    chk(16'(high_b), 16'h0208);
    w16(T16WM_ADDR_CMP_A_LO, 16'h00FF);
    cycles(1100);
    measure(520);
    chk(16'(high_a), 16'h0208);
    w16(T16WM_ADDR_CMP_A_LO, 16'h0040);
    cycles(1100);
    measure(510);
    chk(16'(high_a), 16'h0080);
  endtask

  // Phase and frequency correct, top from channel A compare
  task t_pfc;
    w16(T16WM_ADDR_CMP_A_LO, 16'h0020);
    w16(T16WM_ADDR_CMP_B_LO, 16'h0008);
    setup(8'hA1, 8'h11);
    wait_ovf(100);
    cycles(100);
    measure(64);
    chk(16'(high_a), 16'h0040);
    chk(16'(high_b), 16'h0010);
  endtask

  task t_toggle;
    w16(T16WM_ADDR_CMP_A_LO, 16'h000F);
    setup(8'h43, 8'h19);
    wait_ovf(300);
    cycles(300);
    measure(64);
    chk(16'(toggles), 16'h0004);
    setup(8'h43, 8'h09);
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk_in);
      gpio_a <= 8'(i);
      cycles(3);
      chk(16'(pin_a), 16'(i));
    end
  endtask

  initial begin
    repeat (3) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    t_regs;
    t_force;
    t_pin;
    t_ovf;
    t_fast;
    t_dual;
    t_toggle;
    t_pfc;
    give_verdict;
  end
endmodule
